/* verilog/abx_defs.svh */
// Constants of the logical-op, carry-branch and bit-clear executor
`ifndef ABX_DEFS_SVH
`define ABX_DEFS_SVH

// Register offsets (byte addresses)
`define ABX_OFS_ACC       16'h0000
`define ABX_OFS_STATUS    16'h0004
`define ABX_OFS_BANK      16'h0008
`define ABX_OFS_INDEX     16'h000C
`define ABX_OFS_CTRL      16'h0010
`define ABX_OFS_PC        16'h0014
`define ABX_OFS_PHASE     16'h0018
`define ABX_MEM_WIN       2'h1

// Status and control field positions
`define ABX_ST_C          0
`define ABX_ST_Z          2
`define ABX_ST_N          4
`define ABX_CTRL_EXT      0

// Reset values
`define ABX_RST_ACC       8'h00
`define ABX_RST_STATUS    8'h00
`define ABX_RST_CTRL      1'h0

// Opcode fields
`define ABX_OPC_ANDL      8'h0B
`define ABX_OPC_ANDF      6'h05
`define ABX_OPC_BC        8'hE2
`define ABX_OPC_BCF       4'h9

// Address resolution limits
`define ABX_IDX_LIMIT     8'h5F
`define ABX_ACCESS_SPLIT  8'h60

// Phases per instruction cycle, minus one
`define ABX_LAST_PHASE    2'h3

`endif

/* verilog/abx_pkg.sv */
// Types of the logical-op, carry-branch and bit-clear executor
package abx_pkg;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_DECODE  = 6'h02,
        ST_READ    = 6'h04,
        ST_PROC    = 6'h08,
        ST_WRITE   = 6'h10,
        ST_IDLECYC = 6'h20
    } abx_state_e;

    typedef enum logic [4:0] {
        OP_NONE = 5'h01,
        OP_ANDL = 5'h02,
        OP_ANDF = 5'h04,
        OP_BC   = 5'h08,
        OP_BCF  = 5'h10
    } abx_op_e;

endpackage : abx_pkg

/* verilog/abx_exec.sv */
// Executor for literal-AND, register-AND, branch-on-carry and bit-clear
//
// Contract
// - High byte 0000 1011 ANDs the low-byte literal into the accumulator.
// - Prefix 0001 01 ANDs accumulator with file register; only N and Z change.
// - Register-AND destination bit 0 writes accumulator, 1 writes the file register.
// - Bank-access bit 0 resolves the address in the quick-access bank, bank ignored.
// - Bank-access bit 1 joins the bank select register with the file address.
// - Extended set, bank-access 0 and address up to 95 use indexed literal offset.
// - High byte 1110 0010 is branch-on-carry with signed low-byte displacement.
// - The branch is taken only when carry is one, else execution falls through.
// - A taken branch adds twice the signed displacement to the advanced counter.
// - Target equals branch address plus two plus twice the displacement.
// - Branch takes one cycle untaken, two taken with an idle second cycle.
// - Nibble 1001 clears the bit chosen by the next three bits of the register.
// - Branch-on-carry and bit-clear leave every status flag unchanged.
`include "abx_defs.svh"

module abx_exec #(
    parameter int PC_W   = 21,
    parameter int BANK_W = 4
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                instr_valid,
    input  wire logic [15:0]         instr_word,
    output logic                     instr_ready,
    output logic [PC_W-1:0]          pc,
    output logic                     retire,
    output abx_pkg::abx_state_e      phase,
    input  wire logic [15:0]         reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata
);
    import abx_pkg::*;

    localparam int ADDR_W = BANK_W + 8;
    localparam int DEPTH  = 1 << ADDR_W;

    abx_state_e          state_r;
    abx_state_e          state_nxt;
    abx_op_e             op_r;
    abx_op_e             dec_op;
    logic [15:0]         instr_r;
    logic [7:0]          acc_r;
    logic [7:0]          status_r;
    logic [BANK_W-1:0]   bsr_r;
    logic [ADDR_W-1:0]   index_r;
    logic                ext_r;
    logic [PC_W-1:0]     pc_r;
    logic [ADDR_W-1:0]   eff_addr_r;
    logic [ADDR_W-1:0]   eff_addr_nxt;
    logic [7:0]          operand_r;
    logic [7:0]          result_r;
    logic                take_r;
    logic [1:0]          idle_cnt_r;
    logic                ready_r;
    logic                retire_r;
    logic [31:0]         rdata_r;
    logic [7:0]          mem [0:DEPTH-1];
    logic                accept;
    logic                core_we;
    logic                bus_acc_wr;
    logic                bus_st_wr;
    logic                bus_mem_wr;
    logic [PC_W-1:0]     disp_ext;
    logic [7:0]          file_f;

    assign file_f   = instr_r[7:0];
    assign accept   = (state_r == ST_IDLE) && instr_valid;
    assign disp_ext = {{(PC_W - 9){instr_r[7]}}, instr_r[7:0], 1'b0};

    // Opcode decode
    always_comb begin
        if (instr_r[15:8] == `ABX_OPC_ANDL) begin
            dec_op = OP_ANDL;
        end else if (instr_r[15:10] == `ABX_OPC_ANDF) begin
            dec_op = OP_ANDF;
        end else if (instr_r[15:8] == `ABX_OPC_BC) begin
            dec_op = OP_BC;
        end else if (instr_r[15:12] == `ABX_OPC_BCF) begin
            dec_op = OP_BCF;
        end else begin
            dec_op = OP_NONE;
        end
    end

    // File address resolution
    always_comb begin
        if (instr_r[8]) begin
            eff_addr_nxt = {bsr_r, file_f};
        end else if (ext_r && (file_f <= `ABX_IDX_LIMIT)) begin
            eff_addr_nxt = index_r + ADDR_W'(file_f);
        end else if (file_f < `ABX_ACCESS_SPLIT) begin
            eff_addr_nxt = {{BANK_W{1'b0}}, file_f};
        end else begin
            eff_addr_nxt = {{BANK_W{1'b1}}, file_f};
        end
    end

    // Phase sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = ST_DECODE;
                end
            end
            ST_DECODE: begin
                state_nxt = ST_READ;
            end
            ST_READ: begin
                state_nxt = ST_PROC;
            end
            ST_PROC: begin
                state_nxt = ST_WRITE;
            end
            ST_WRITE: begin
                if (op_r == OP_BC && take_r) begin
                    state_nxt = ST_IDLECYC;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLECYC: begin
                if (idle_cnt_r == `ABX_LAST_PHASE) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            idle_cnt_r <= 2'h0;
            ready_r    <= 1'b0;
            retire_r   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            ready_r    <= (state_nxt == ST_IDLE);
            retire_r   <= (state_r == ST_WRITE && state_nxt == ST_IDLE)
                          || (state_r == ST_IDLECYC && state_nxt == ST_IDLE);
            if (state_r == ST_IDLECYC) begin
                idle_cnt_r <= idle_cnt_r + 2'h1;
            end else begin
                idle_cnt_r <= 2'h0;
            end
        end
    end

    // Instruction capture, decode and operand stages
    always_ff @(posedge clock) begin
        if (rst) begin
            instr_r    <= 16'h0000;
            op_r       <= OP_NONE;
            eff_addr_r <= '0;
            operand_r  <= 8'h00;
            result_r   <= 8'h00;
            take_r     <= 1'b0;
        end else begin
            if (accept) begin
                instr_r <= instr_word;
            end
            if (state_r == ST_DECODE) begin
                op_r       <= dec_op;
                eff_addr_r <= eff_addr_nxt;
            end
            if (state_r == ST_READ) begin
                operand_r <= mem[eff_addr_r];
            end
            if (state_r == ST_PROC) begin
                take_r <= status_r[`ABX_ST_C];
                case (op_r)
                    OP_ANDL: begin
                        result_r <= acc_r & file_f;
                    end
                    OP_ANDF: begin
                        result_r <= acc_r & operand_r;
                    end
                    OP_BCF: begin
                        result_r <= operand_r & ~(8'h01 << instr_r[11:9]);
                    end
                    default: begin
                        result_r <= operand_r;
                    end
                endcase
            end
        end
    end

    assign core_we = (state_r == ST_WRITE)
                     && ((op_r == OP_ANDF && instr_r[9]) || op_r == OP_BCF);

    assign bus_acc_wr = reg_wr && reg_addr == `ABX_OFS_ACC;
    assign bus_st_wr  = reg_wr && reg_addr == `ABX_OFS_STATUS;
    assign bus_mem_wr = reg_wr && reg_addr[15:14] == `ABX_MEM_WIN && !core_we;

    // Accumulator
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_r <= `ABX_RST_ACC;
        end else if (state_r == ST_WRITE
                     && (op_r == OP_ANDL || (op_r == OP_ANDF && !instr_r[9]))) begin
            acc_r <= result_r;
        end else if (bus_acc_wr) begin
            acc_r <= reg_wdata[7:0];
        end
    end

    // status flags, N and Z only
    always_ff @(posedge clock) begin
        if (rst) begin
            status_r <= `ABX_RST_STATUS;
        end else if (state_r == ST_WRITE && (op_r == OP_ANDL || op_r == OP_ANDF)) begin
            status_r[`ABX_ST_N] <= result_r[7];
            status_r[`ABX_ST_Z] <= (result_r == 8'h00);
        end else if (bus_st_wr) begin
            status_r <= reg_wdata[7:0];
        end
    end

    // Bank, index base and extended-set control
    always_ff @(posedge clock) begin
        if (rst) begin
            bsr_r   <= '0;
            index_r <= '0;
            ext_r   <= `ABX_RST_CTRL;
        end else if (reg_wr) begin
            if (reg_addr == `ABX_OFS_BANK) begin
                bsr_r <= reg_wdata[BANK_W-1:0];
            end else if (reg_addr == `ABX_OFS_INDEX) begin
                index_r <= reg_wdata[ADDR_W-1:0];
            end else if (reg_addr == `ABX_OFS_CTRL) begin
                ext_r <= reg_wdata[`ABX_CTRL_EXT];
            end
        end
    end

    // Program counter
    always_ff @(posedge clock) begin
        if (rst) begin
            pc_r <= '0;
        end else if (accept) begin
            pc_r <= pc_r + PC_W'(2);
        end else if (state_r == ST_WRITE && op_r == OP_BC && take_r) begin
            pc_r <= pc_r + disp_ext;
        end else if (reg_wr && reg_addr == `ABX_OFS_PC) begin
            pc_r <= reg_wdata[PC_W-1:0];
        end
    end

    // Data memory, core write before bus write
    always_ff @(posedge clock) begin
        if (core_we) begin
            mem[eff_addr_r] <= result_r;
        end else if (bus_mem_wr) begin
            mem[reg_addr[ADDR_W+1:2]] <= reg_wdata[7:0];
        end
    end

    // Read data, valid one cycle after the strobe only
    always_ff @(posedge clock) begin
        if (rst || !reg_rd) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_addr == `ABX_OFS_ACC) begin
            rdata_r <= {24'h00_0000, acc_r};
        end else if (reg_addr == `ABX_OFS_STATUS) begin
            rdata_r <= {24'h00_0000, status_r};
        end else if (reg_addr == `ABX_OFS_BANK) begin
            rdata_r <= 32'(bsr_r);
        end else if (reg_addr == `ABX_OFS_INDEX) begin
            rdata_r <= 32'(index_r);
        end else if (reg_addr == `ABX_OFS_CTRL) begin
            rdata_r <= 32'(ext_r);
        end else if (reg_addr == `ABX_OFS_PC) begin
            rdata_r <= 32'(pc_r);
        end else if (reg_addr == `ABX_OFS_PHASE) begin
            rdata_r <= 32'(state_r);
        end else if (reg_addr[15:14] == `ABX_MEM_WIN) begin
            rdata_r <= {24'h00_0000, mem[reg_addr[ADDR_W+1:2]]};
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign instr_ready = ready_r;
    assign pc          = pc_r;
    assign retire      = retire_r;
    assign phase       = state_r;
    assign reg_rdata   = rdata_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence data_phases_s;
        state_r == ST_READ ##1 state_r == ST_PROC ##1 state_r == ST_WRITE;
    endsequence
    sequence idle_cycle_s;
        (state_r == ST_IDLECYC)[*4] ##1 state_r == ST_IDLE;
    endsequence

    phase_order_a: assert property (state_r == ST_DECODE |=> data_phases_s ##1 state_r != ST_DECODE)
        else $error("phases out of order");
    literal_and_a: assert property ((state_r == ST_WRITE && op_r == OP_ANDL && !bus_acc_wr)
        |=> acc_r == ($past(acc_r) & $past(instr_r[7:0])))
        else $error("literal AND result wrong");
    reg_and_flags_a: assert property ((state_r == ST_WRITE && op_r == OP_ANDF && !bus_st_wr)
        |=> status_r[`ABX_ST_Z] == ($past(result_r) == 8'h00) && status_r[`ABX_ST_N] == $past(result_r[7])
            && status_r[`ABX_ST_C] == $past(status_r[`ABX_ST_C]))
        else $error("register AND flags wrong");
    and_dest_a: assert property ((state_r == ST_WRITE && op_r == OP_ANDF && instr_r[9] && !bus_acc_wr)
        |-> core_we ##1 acc_r == $past(acc_r))
        else $error("register AND destination wrong");
    access_addr_a: assert property ((state_r == ST_DECODE && !instr_r[8] && !(ext_r && file_f <= `ABX_IDX_LIMIT))
        |=> eff_addr_r == {{BANK_W{$past(file_f) >= `ABX_ACCESS_SPLIT}}, $past(file_f)})
        else $error("quick-access address wrong");
    bank_addr_a: assert property ((state_r == ST_DECODE && instr_r[8])
        |=> eff_addr_r == {$past(bsr_r), $past(file_f)})
        else $error("banked address wrong");
    index_addr_a: assert property ((state_r == ST_DECODE && !instr_r[8] && ext_r && file_f <= `ABX_IDX_LIMIT)
        |=> eff_addr_r == $past(index_r) + ADDR_W'($past(file_f)))
        else $error("indexed address wrong");
    branch_skip_a: assert property ((state_r == ST_WRITE && op_r == OP_BC && !take_r && !reg_wr)
        |=> state_r == ST_IDLE && pc_r == $past(pc_r))
        else $error("untaken branch moved counter");
    branch_target_a: assert property ((state_r == ST_WRITE && op_r == OP_BC && take_r)
        |=> pc_r == $past(pc_r) + PC_W'(2 * $signed($past(instr_r[7:0]))))
        else $error("branch target wrong");
    branch_idle_a: assert property ((state_r == ST_WRITE && op_r == OP_BC && take_r) |=> idle_cycle_s)
        else $error("taken branch idle cycle wrong");
    flags_keep_a: assert property ((state_r == ST_WRITE && (op_r == OP_BC || op_r == OP_BCF) && !bus_st_wr)
        |=> status_r == $past(status_r))
        else $error("flags changed");
    bit_clear_a: assert property ((state_r == ST_WRITE && op_r == OP_BCF)
        |-> core_we && !result_r[instr_r[11:9]])
        else $error("bit clear wrong");
    bit_keep_a: assert property ((state_r == ST_WRITE && op_r == OP_BCF)
        |-> ((result_r ^ operand_r) & ~(8'h01 << instr_r[11:9])) == 8'h00)
        else $error("bit clear disturbed other bits");
endmodule : abx_exec

/* sim/tb_and_branch_carry_bitclear_exec.sv */
// Self-checking bench of the AND, carry-branch and bit-clear executor
`include "abx_defs.svh"

module tb_and_branch_carry_bitclear_exec;
    timeunit 1ns;
    timeprecision 100ps;
    import abx_pkg::*;

    logic               clock;
    logic               rst;
    logic               instr_valid;
    logic [15:0]        instr_word;
    logic               instr_ready;
    logic [20:0]        pc;
    logic               retire;
    abx_state_e         phase;
    logic [15:0]        reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    int                 mismatches;
    int                 n_tests;

    abx_exec #(.PC_W(21), .BANK_W(4)) dut_u (
        .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .pc(pc), .retire(retire), .phase(phase),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic complete_run();
        $display("Tests %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [15:0] addr, input logic [31:0] data);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] addr, output logic [31:0] data);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : bus_rd

    task automatic bus_chk(input logic [15:0] addr, input logic [31:0] exp, input string what);
        logic [31:0] d;
        bus_rd(addr, d);
        check(d, exp, what);
    endtask : bus_chk

    function automatic logic [15:0] maddr(input logic [11:0] k);
        return {2'b01, k, 2'b00};
    endfunction : maddr

    // Runs one instruction and checks its phase walk and length
    task automatic exec(input logic [15:0] word, input int exp_cyc);
        int cnt;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word  <= word;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        cnt = 1;
        check(phase, ST_DECODE, "first phase");
        check(instr_ready, 1'b0, "ready while busy");
        while (retire !== 1'b1) begin
            if (cnt > 40) begin
                mismatches++;
                $display("Error at %0t: no retire", $time);
                complete_run();
            end
            @(posedge clock);
            #1;
            cnt++;
            if (cnt == 4) check(phase, ST_WRITE, "fourth phase");
        end
        check(cnt, exp_cyc, "cycles to retire");
        check(instr_ready, 1'b1, "ready after retire");
    endtask : exec

    task automatic do_andl(input logic [7:0] acc0, input logic [7:0] k);
        logic [7:0] res;
        res = acc0 & k;
        bus_wr(`ABX_OFS_STATUS, 32'h0000_0001);
        bus_wr(`ABX_OFS_ACC, {24'h0, acc0});
        exec({8'h0B, k}, 5);
        bus_chk(`ABX_OFS_ACC, {24'h0, res}, "literal and result");
        bus_chk(`ABX_OFS_STATUS, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, 1'b1}, "literal and flags");
        $display("Literal and %h & %h done", acc0, k);
    endtask : do_andl

    task automatic do_andf(input logic [7:0] acc0, input logic [7:0] mval, input logic d, input logic a,
                           input logic [7:0] f, input logic [11:0] k);
        logic [7:0] res;
        res = acc0 & mval;
        bus_wr(`ABX_OFS_STATUS, 32'h0000_0001);
        bus_wr(`ABX_OFS_ACC, {24'h0, acc0});
        bus_wr(maddr(k), {24'h0, mval});
        exec({6'h05, d, a, f}, 5);
        bus_chk(`ABX_OFS_ACC, {24'h0, (d ? acc0 : res)}, "register and accumulator");
        bus_chk(maddr(k), {24'h0, (d ? res : mval)}, "register and file");
        bus_chk(`ABX_OFS_STATUS, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, 1'b1}, "register and flags");
        $display("Register and f=%h a=%b d=%b done", f, a, d);
    endtask : do_andf

    task automatic do_bc(input logic c, input logic [7:0] n);
        logic [20:0] target;
        target = 21'h01000 + 21'h2 + (c ? {{12{n[7]}}, n, 1'b0} : 21'h0);
        bus_wr(`ABX_OFS_PC, 32'h0000_1000);
        bus_wr(`ABX_OFS_STATUS, {27'h0, 4'hA, c});
        exec({8'hE2, n}, c ? 9 : 5);
        check(pc, target, "branch target");
        bus_chk(`ABX_OFS_PC, {11'h0, target}, "counter after branch");
        bus_chk(`ABX_OFS_STATUS, {27'h0, 4'hA, c}, "flags after branch");
        $display("Branch c=%b n=%h done", c, n);
    endtask : do_bc

    task automatic do_bcf(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [11:0] k,
                          input logic [7:0] v);
        logic [7:0] mask;
        mask = ~(8'h01 << b);
        bus_wr(`ABX_OFS_STATUS, 32'h0000_0015);
        bus_wr(maddr(k), {24'h0, v});
        exec({4'h9, b, a, f}, 5);
        bus_chk(maddr(k), {24'h0, v & mask}, "bit clear result");
        bus_chk(`ABX_OFS_STATUS, 32'h0000_0015, "flags after bit clear");
        $display("Bit clear b=%0d v=%h done", b, v);
    endtask : do_bcf

    task automatic test_reset();
        bus_chk(`ABX_OFS_ACC, 32'h0, "accumulator reset");
        bus_chk(`ABX_OFS_STATUS, 32'h0, "status reset");
        bus_chk(`ABX_OFS_CTRL, 32'h0, "control reset");
        bus_chk(16'h0020, 32'h0, "unmapped read");
        bus_wr(`ABX_OFS_PHASE, 32'h0000_003F);
        bus_chk(`ABX_OFS_PHASE, 32'h0000_0001, "phase read only");
        check(pc, 21'h0, "counter reset");
        $display("Reset test done");
    endtask : test_reset

    task automatic test_unknown();
        bus_wr(`ABX_OFS_STATUS, 32'h0000_0001);
        bus_wr(`ABX_OFS_ACC, 32'h0000_005A);
        exec(16'hF000, 5);
        check(pc, 21'h00_0002, "counter advance");
        bus_chk(`ABX_OFS_ACC, 32'h0000_005A, "unknown op accumulator");
        bus_chk(`ABX_OFS_STATUS, 32'h0000_0001, "unknown op flags");
        $display("Unknown opcode test done");
    endtask : test_unknown

    initial begin
        rst         = 1'b1;
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
        reg_addr    = 16'h0000;
        reg_wdata   = 32'h0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        mismatches  = 0;
        n_tests     = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        test_reset();
        test_unknown();
        do_andl(8'hA3, 8'h5F);
        do_andl(8'hA3, 8'h00);
        do_andl(8'hFF, 8'h80);
        bus_wr(`ABX_OFS_BANK, 32'h0000_0002);
        do_andf(8'hF0, 8'h3C, 1'b0, 1'b1, 8'h33, 12'h233);
        do_andf(8'hF0, 8'h3C, 1'b1, 1'b1, 8'h33, 12'h233);
        do_andf(8'h0F, 8'hF0, 1'b1, 1'b1, 8'h44, 12'h244);
        do_andf(8'hFF, 8'h81, 1'b0, 1'b0, 8'h10, 12'h010);
        do_andf(8'hFF, 8'h7E, 1'b0, 1'b0, 8'h80, 12'hF80);
        bus_wr(`ABX_OFS_CTRL, 32'h0000_0001);
        bus_wr(`ABX_OFS_INDEX, 32'h0000_0300);
        do_andf(8'hFF, 8'h5A, 1'b0, 1'b0, 8'h05, 12'h305);
        do_andf(8'hFF, 8'hA5, 1'b1, 1'b0, 8'h5F, 12'h35F);
        do_andf(8'hFF, 8'h33, 1'b0, 1'b0, 8'h60, 12'hF60);
        do_andf(8'hFF, 8'h66, 1'b0, 1'b1, 8'h05, 12'h205);
        bus_wr(`ABX_OFS_CTRL, 32'h0000_0000);
        do_bc(1'b0, 8'h05);
        do_bc(1'b1, 8'h05);
        do_bc(1'b1, 8'h80);
        do_bc(1'b1, 8'h7F);
        do_bc(1'b1, 8'hFF);
        for (int b = 0; b < 8; b++) begin
            do_bcf(b[2:0], 1'b1, 8'h21, 12'h221, 8'hFF);
        end
        do_bcf(3'h7, 1'b0, 8'h20, 12'h020, 8'hC7);
        do_bcf(3'h0, 1'b0, 8'h20, 12'h020, 8'h5A);
        $display("Bit clear tests done");
        complete_run();
    end
endmodule : tb_and_branch_carry_bitclear_exec
